// *** rtl/dps_pkg.sv ***
// Purpose: Shared constants and types for the digital pattern sequencer
// Assumes: 32-bit classic Wishbone register access, 125 MHz pattern clock
// Notes: Byte offsets are word aligned; entries are appended in order
package dps_pkg;
  localparam int DATA_W = 16;
  localparam int FLAG_W = 6;
  localparam int PIN_FLAGS = 4;
  localparam int REP_W = 10;
  localparam int IDX_W = 16;
  localparam int CNT_W = 17;
  localparam logic [CNT_W-1:0] MEM_DEPTH = 17'h10000;
  localparam int ADR_W = 8;

  // Register byte offsets
  localparam logic [ADR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADR_W-1:0] REG_STATIC = 8'h08;
  localparam logic [ADR_W-1:0] REG_ENTRY_LO = 8'h0C;
  localparam logic [ADR_W-1:0] REG_ENTRY_HI = 8'h10;
  localparam logic [ADR_W-1:0] REG_POSITION = 8'h14;
  localparam logic [ADR_W-1:0] REG_COUNT = 8'h18;

  // Field positions
  localparam int CTRL_RUN = 0;
  localparam int CTRL_STATIC = 1;
  localparam int CTRL_CLEAR = 2;
  localparam int CTRL_FEN_LSB = 4;
  localparam int STAT_PEND_LOOP = 2;
  localparam int STAT_FIN_LSB = 4;
  localparam int FLAG_LSB = 16;
  localparam int HI_LOOP = 16;
  localparam int HI_END = 17;
  localparam int POS_CNT_LSB = 16;
  localparam int DAC_BIT = 5;

  localparam logic [PIN_FLAGS-1:0] FLAG_OE_OFF = 4'hF;

  typedef enum logic [1:0] {
    DPS_IDLE = 2'h0,
    DPS_PRE = 2'h1,
    DPS_LOOP = 2'h3
  } dps_state_t;

  typedef struct packed {
    logic mark_end;
    logic mark_loop;
    logic [REP_W-1:0] rep;
    logic [FLAG_W-1:0] flags;
    logic [DATA_W-1:0] data;
  } dps_entry_t;
endpackage : dps_pkg

// *** rtl/dps_top.sv ***
// Purpose: Looping digital pattern sequencer with Wishbone register access
// Assumes: Pattern clock is clk_i; flag pins resolved outside from the enables
// Notes: Memory is loaded only while the sequencer is idle
// What this block does
// - One pattern per clock, on rising edge.
// - Per-flag enable drives or releases each flag pin.
// - Static mode holds configured levels, ignoring patterns.
// - Preamble entries play exactly once at start.
// - Data, flag and DAC outputs low during setup and teardown.
// - Stopping jumps straight to low data, flag and DAC outputs.
// - Loop end wraps to loop start, no gap.
// - Loop body repeats inclusively until test stops.
// - Entry held repeat-count clocks; zero repeat skipped.
// - At most 65,536 entries, repeat up to 1,023.
// - Sixteen data bits, six flags, bit four unused.
`timescale 1ns/1ps
module dps_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [dps_pkg::ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Pattern pins to and from the device under test
  output logic [dps_pkg::DATA_W-1:0] pattern_data_bits_o,
  output logic [dps_pkg::PIN_FLAGS-1:0] pattern_flag_bits_o,
  output logic [dps_pkg::PIN_FLAGS-1:0] pattern_flag_oe_n_o,
  input wire logic [dps_pkg::PIN_FLAGS-1:0] pattern_flag_bits_i,
  output logic dac_update_flag_o
);
  import dps_pkg::*;

  typedef struct packed {
    dps_state_t st;
    logic [IDX_W-1:0] idx;
    logic [REP_W-1:0] cnt;
    logic [IDX_W-1:0] loop_idx;
    logic [CNT_W-1:0] count;
    logic pend_loop;
    logic [DATA_W+FLAG_W-1:0] stage;
    logic run;
    logic static_mode;
    logic [PIN_FLAGS-1:0] fen;
    logic [DATA_W-1:0] static_data;
    logic [FLAG_W-1:0] static_flags;
    logic ack;
    logic [31:0] dat;
    logic [DATA_W-1:0] q;
    logic [PIN_FLAGS-1:0] f;
    logic [PIN_FLAGS-1:0] oe_n;
    logic dac;
    logic [PIN_FLAGS-1:0] sync1;
    logic [PIN_FLAGS-1:0] sync2;
  } dps_regs_t;

  dps_regs_t s;
  dps_regs_t next_s;

  dps_entry_t mem [0:MEM_DEPTH-1];

  logic mem_we;
  logic [IDX_W-1:0] mem_waddr;
  dps_entry_t mem_wdata;

  function automatic logic [31:0] dps_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : dps_merge

  always_comb begin
    logic [31:0] cur_ctrl;
    logic [31:0] cur_static;
    logic [31:0] cur_lo;
    logic [31:0] wd;
    logic [ADR_W-1:0] a;
    logic wr;
    logic rep_last;
    logic is_last;
    logic [IDX_W-1:0] last_idx;
    dps_entry_t cur;
    dps_entry_t prev;
    next_s = s;
    mem_we = 1'b0;
    mem_waddr = s.count[IDX_W-1:0];
    mem_wdata = '0;
    a = {adr_i[ADR_W-1:2], 2'b00};
    cur_ctrl = '0;
    cur_ctrl[CTRL_RUN] = s.run;
    cur_ctrl[CTRL_STATIC] = s.static_mode;
    cur_ctrl[CTRL_FEN_LSB +: PIN_FLAGS] = s.fen;
    cur_static = '0;
    cur_static[DATA_W-1:0] = s.static_data;
    cur_static[FLAG_LSB +: FLAG_W] = s.static_flags;
    cur_lo = '0;
    cur_lo[DATA_W-1:0] = s.stage[DATA_W-1:0];
    cur_lo[FLAG_LSB +: FLAG_W] = s.stage[DATA_W +: FLAG_W];
    wd = '0;
    wr = cyc_i && stb_i && we_i && s.ack;
    cur = mem[s.idx];
    prev = mem[IDX_W'(s.count - 17'h00001)];
    last_idx = IDX_W'(s.count - 17'h00001);
    rep_last = (s.cnt == REP_W'(cur.rep - 10'h001));
    is_last = cur.mark_end || (s.idx == last_idx);

    // Single-cycle Wishbone answer; write acts at the acked edge
    next_s.ack = cyc_i && stb_i && !s.ack;
    next_s.dat = '0;
    if (cyc_i && stb_i && !s.ack && !we_i) begin
      unique case (a)
        REG_CTRL: next_s.dat = cur_ctrl;
        REG_STATUS: begin
          next_s.dat[$bits(dps_state_t)-1:0] = s.st;
          next_s.dat[STAT_PEND_LOOP] = s.pend_loop;
          next_s.dat[STAT_FIN_LSB +: PIN_FLAGS] = s.sync2;
        end
        REG_STATIC: next_s.dat = cur_static;
        REG_ENTRY_LO: next_s.dat = cur_lo;
        REG_POSITION: begin
          next_s.dat[IDX_W-1:0] = s.idx;
          next_s.dat[POS_CNT_LSB +: REP_W] = s.cnt;
        end
        REG_COUNT: next_s.dat[CNT_W-1:0] = s.count;
        default: next_s.dat = '0;
      endcase
    end
    if (wr) begin
      unique case (a)
        REG_CTRL: begin
          wd = dps_merge(cur_ctrl, dat_i, sel_i);
          next_s.run = wd[CTRL_RUN];
          next_s.static_mode = wd[CTRL_STATIC];
          next_s.fen = wd[CTRL_FEN_LSB +: PIN_FLAGS];
          if (wd[CTRL_CLEAR] && s.st == DPS_IDLE) begin
            next_s.count = '0;
            next_s.loop_idx = '0;
            next_s.pend_loop = 1'b0;
          end
        end
        REG_STATIC: begin
          wd = dps_merge(cur_static, dat_i, sel_i);
          next_s.static_data = wd[DATA_W-1:0];
          next_s.static_flags = wd[FLAG_LSB +: FLAG_W];
        end
        REG_ENTRY_LO: begin
          wd = dps_merge(cur_lo, dat_i, sel_i);
          next_s.stage = {wd[FLAG_LSB +: FLAG_W], wd[DATA_W-1:0]};
        end
        REG_ENTRY_HI: begin
          wd = dps_merge(32'h00000000, dat_i, sel_i);
          if (s.st == DPS_IDLE) begin
            if (wd[REP_W-1:0] != '0) begin
              if (s.count < MEM_DEPTH) begin
                mem_we = 1'b1;
                mem_wdata.mark_end = wd[HI_END];
                mem_wdata.mark_loop = wd[HI_LOOP] || s.pend_loop;
                mem_wdata.rep = wd[REP_W-1:0];
                mem_wdata.flags = s.stage[DATA_W +: FLAG_W];
                mem_wdata.data = s.stage[DATA_W-1:0];
                if (mem_wdata.mark_loop) begin
                  next_s.loop_idx = s.count[IDX_W-1:0];
                end
                next_s.count = s.count + 17'h00001;
                next_s.pend_loop = 1'b0;
              end
            end else begin
              // Zero repeat is not stored; its markers move to neighbours
              if (wd[HI_LOOP]) begin
                next_s.pend_loop = 1'b1;
              end
              if (wd[HI_END] && s.count != '0) begin
                mem_we = 1'b1;
                mem_waddr = last_idx;
                mem_wdata = prev;
                mem_wdata.mark_end = 1'b1;
              end
            end
          end
        end
        default: wd = '0;
      endcase
    end

    // Sequencer
    if (!s.run) begin
      next_s.st = DPS_IDLE;
      next_s.idx = '0;
      next_s.cnt = '0;
    end else if (s.st == DPS_IDLE) begin
      if (s.count != '0) begin
        next_s.st = (s.loop_idx == '0) ? DPS_LOOP : DPS_PRE;
        next_s.idx = '0;
        next_s.cnt = '0;
      end
    end else if (rep_last) begin
      next_s.cnt = '0;
      if (is_last) begin
        next_s.idx = s.loop_idx;
        next_s.st = DPS_LOOP;
      end else begin
        next_s.idx = s.idx + 16'h0001;
        if (IDX_W'(s.idx + 16'h0001) == s.loop_idx) begin
          next_s.st = DPS_LOOP;
        end
      end
    end else begin
      next_s.cnt = s.cnt + 10'h001;
    end

    // Registered pin drive, one pattern per clock
    next_s.oe_n = ~s.fen;
    if (!s.run) begin
      next_s.q = '0;
      next_s.f = '0;
      next_s.dac = 1'b0;
    end else if (s.static_mode) begin
      next_s.q = s.static_data;
      next_s.f = s.static_flags[PIN_FLAGS-1:0];
      next_s.dac = s.static_flags[DAC_BIT];
    end else if (s.st != DPS_IDLE) begin
      next_s.q = cur.data;
      next_s.f = cur.flags[PIN_FLAGS-1:0];
      next_s.dac = cur.flags[DAC_BIT];
    end else begin
      next_s.q = '0;
      next_s.f = '0;
      next_s.dac = 1'b0;
    end

    next_s.sync1 = pattern_flag_bits_i;
    next_s.sync2 = s.sync1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.oe_n <= FLAG_OE_OFF;
    end else begin
      s <= next_s;
    end
  end

  always_ff @(posedge clk_i) begin
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end

  assign dat_o = s.dat;
  assign ack_o = s.ack;
  assign pattern_data_bits_o = s.q;
  assign pattern_flag_bits_o = s.f;
  assign pattern_flag_oe_n_o = s.oe_n;
  assign dac_update_flag_o = s.dac;
endmodule : dps_top

// *** testbench/digital_pattern_sequencer_test.sv ***
// Purpose: Self-checking bench for the pattern sequencer
// Assumes: Wishbone answer waited for, outputs follow a stop or static start in one cycle, a pattern start in two
// Notes: Pattern words sampled one ns after the rising edge
`timescale 1ns/1ps
module digital_pattern_sequencer_test;
  import dps_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o, dac_update_flag_o;
  logic [7:0] adr_i = '0;
  logic [3:0] sel_i = 4'hF, pattern_flag_bits_o, pattern_flag_oe_n_o, pin;
  logic [31:0] dat_i = '0, dat_o, q;
  logic [15:0] pattern_data_bits_o;
  logic [20:0] seq [10] = '{21'h011111, 21'h102222, 21'h102222, 21'h0F3333, 21'h102222,
    21'h102222, 21'h0F3333, 21'h102222, 21'h102222, 21'h0F3333};
  int mismatches = 0, checked = 0, n;
  dps_top i_dps_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .pattern_data_bits_o(pattern_data_bits_o), .pattern_flag_bits_o(pattern_flag_bits_o),
    .pattern_flag_oe_n_o(pattern_flag_oe_n_o), .pattern_flag_bits_i(pin),
    .dac_update_flag_o(dac_update_flag_o));
  dps_dut_model i_dps_dut_model (.oe_n_i(pattern_flag_oe_n_o), .drv_i(pattern_flag_bits_o),
    .pin_o(pin));
  initial forever #4 clk_i = ~clk_i;
  task automatic end_sim;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : cmp
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (ack_o !== 1'b1) begin
      mismatches++;
      $display("unexpected at %0t: bus timeout", $time);
      end_sim();
    end
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmp(q, e);
  endtask : rd
  task automatic word(input logic [31:0] e);
    @(posedge clk_i);
    #1;
    cmp({11'h0, dac_update_flag_o, pattern_flag_bits_o, pattern_data_bits_o}, e);
  endtask : word
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    word(32'h0);
    cmp(pattern_flag_oe_n_o, 4'hF);
    rd(REG_COUNT, 32'h0);
    rd(8'h40, 32'h0);
    bus(1'b1, REG_CTRL, 32'h50);
    repeat (4) @(posedge clk_i);
    cmp(pattern_flag_oe_n_o, 4'hA);
    rd(REG_STATUS, 32'h20);
    rd(REG_CTRL, 32'h50);
    $display("reset and enables done");
    bus(1'b1, REG_ENTRY_LO, 32'h0001_1111);
    bus(1'b1, REG_ENTRY_HI, 32'h1);
    bus(1'b1, REG_ENTRY_LO, 32'h0000_FFFF);
    bus(1'b1, REG_ENTRY_HI, 32'h0001_0000);
    rd(REG_STATUS, 32'h24);
    bus(1'b1, REG_ENTRY_LO, 32'h0020_2222);
    bus(1'b1, REG_ENTRY_HI, 32'h2);
    bus(1'b1, REG_ENTRY_LO, 32'h001F_3333);
    bus(1'b1, REG_ENTRY_HI, 32'h0002_0001);
    rd(REG_COUNT, 32'h3);
    rd(REG_ENTRY_HI, 32'h0);
    bus(1'b1, REG_CTRL, 32'hF1);
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (pattern_data_bits_o !== 16'h1111 && n < 10);
    if (pattern_data_bits_o !== 16'h1111) begin
      mismatches++;
      $display("unexpected at %0t: pattern start timeout", $time);
      end_sim();
    end
    for (int i = 1; i < 10; i++) word({11'h0, seq[i]});
    @(posedge clk_i);
    bus(1'b1, REG_ENTRY_HI, 32'h1);
    rd(REG_COUNT, 32'h3);
    bus(1'b1, REG_CTRL, 32'hF0);
    word(32'h0);
    rd(REG_POSITION, 32'h0);
    $display("sequence done");
    bus(1'b1, REG_STATIC, 32'h0025_ABCD);
    bus(1'b1, REG_CTRL, 32'hF3);
    word(32'h15ABCD);
    @(posedge clk_i);
    bus(1'b1, REG_CTRL, 32'hF0);
    word(32'h0);
    cmp(pattern_flag_oe_n_o, 4'h0);
    @(posedge clk_i);
    bus(1'b1, REG_CTRL, 32'h04);
    rd(REG_COUNT, 32'h0);
    $display("static stop clear done");
    end_sim();
  end
endmodule : digital_pattern_sequencer_test
bind dps_top dps_top_sva i_dps_top_sva (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
  .ack_o(ack_o), .pattern_data_bits_o(pattern_data_bits_o),
  .pattern_flag_bits_o(pattern_flag_bits_o), .pattern_flag_oe_n_o(pattern_flag_oe_n_o),
  .dac_update_flag_o(dac_update_flag_o));

// *** testbench/dps_dut_model.sv ***
// Purpose: Device under test side of the four flag pins
// Assumes: Active-low enables from the sequencer
// Notes: Holds a fixed level on every released pin
`timescale 1ns/1ps
module dps_dut_model (
  // Sequencer side
  input wire logic [3:0] oe_n_i,
  input wire logic [3:0] drv_i,
  // Resolved pins
  output logic [3:0] pin_o
);
  localparam logic [3:0] FAR_LEVEL = 4'h6;
  assign pin_o = (~oe_n_i & drv_i) | (oe_n_i & FAR_LEVEL);
endmodule : dps_dut_model

// *** testbench/dps_top_sva.sv ***
// Purpose: Port-level assertions for the pattern sequencer
// Assumes: Wishbone answer one cycle after the request
// Notes: Attached by bind from the bench
`timescale 1ns/1ps
module dps_top_sva (
  // Watched ports
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [dps_pkg::ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic [dps_pkg::DATA_W-1:0] pattern_data_bits_o,
  input wire logic [dps_pkg::PIN_FLAGS-1:0] pattern_flag_bits_o,
  input wire logic [dps_pkg::PIN_FLAGS-1:0] pattern_flag_oe_n_o,
  input wire logic dac_update_flag_o
);
  import dps_pkg::*;
  logic quiet;
  logic req;
  assign quiet = pattern_data_bits_o == '0 && pattern_flag_bits_o == '0 && !dac_update_flag_o;
  assign req = cyc_i && stb_i && !ack_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_resp: assert property (req |=> ack_o)
    else $error("request not acknowledged");
  chk_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  chk_dat_idle: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data outside ack");
  chk_unmapped_zero: assert property (req && !we_i && adr_i > 8'h1B |=> dat_o == 32'h0)
    else $error("unmapped read not zero");
  chk_reset_low: assert property ($fell(rst_i) |-> quiet)
    else $error("outputs not low after reset");
  chk_reset_oe: assert property ($fell(rst_i) |-> pattern_flag_oe_n_o == FLAG_OE_OFF)
    else $error("flag pins not released after reset");
  chk_stop_low: assert property (ack_o && we_i && adr_i == REG_CTRL && sel_i[0]
    && !dat_i[CTRL_RUN] |-> ##[1:2] quiet) else $error("outputs not low after stop");
endmodule : dps_top_sva
